// >>> verilog/jtap_defines.svh
`ifndef JTAP_DEFINES_SVH
`define JTAP_DEFINES_SVH

`define JTAP_IR_W          4
`define JTAP_IR_EXTEST     4'h0
`define JTAP_IR_SAMPLE     4'h1
`define JTAP_IR_IDCODE     4'h2
`define JTAP_IR_HIGHZ      4'h3
`define JTAP_IR_BYPASS     4'hF
`define JTAP_IR_CAPTURE    4'h1
`define JTAP_RESET_ONES    5
`define JTAP_ID_VER_LSB    28
`define JTAP_ID_PART_LSB   12
`define JTAP_ID_MFG_LSB    1
`define JTAP_ID_W          32

`endif

// >>> verilog/jtap_pkg.sv
package jtap_pkg;
   typedef enum logic [3:0] {
      JTAP_TLR, JTAP_RTI, JTAP_SEL_DR, JTAP_CAP_DR, JTAP_SHF_DR, JTAP_EX1_DR,
      JTAP_PAU_DR, JTAP_EX2_DR, JTAP_UPD_DR, JTAP_SEL_IR, JTAP_CAP_IR,
      JTAP_SHF_IR, JTAP_EX1_IR, JTAP_PAU_IR, JTAP_EX2_IR, JTAP_UPD_IR
   } jtap_state_t;

   typedef struct packed {
      logic tck;
      logic tms;
      logic tdi;
      logic trst_n;
   } jtap_pins_t;
endpackage

// >>> verilog/jtap_fsm.sv
`timescale 1ns/1ps
`include "jtap_defines.svh"

module jtap_fsm
   import jtap_pkg::*;
(
   input  wire logic        i_ref_clk,
   input  wire logic        i_rst_n,
   input  wire logic        i_tck_rise,
   input  wire logic        i_tms,
   input  wire logic        i_trst_n,
   output jtap_state_t      o_state
);
   typedef struct packed {
      jtap_state_t st;
   } jtap_fsm_q_t;

   jtap_fsm_q_t q_q;
   jtap_fsm_q_t q_d;

   function automatic jtap_state_t jtap_next(input jtap_state_t s, input logic tms);
      case (s)
         JTAP_TLR:    jtap_next = tms ? JTAP_TLR    : JTAP_RTI;
         JTAP_RTI:    jtap_next = tms ? JTAP_SEL_DR : JTAP_RTI;
         JTAP_SEL_DR: jtap_next = tms ? JTAP_SEL_IR : JTAP_CAP_DR;
         JTAP_CAP_DR: jtap_next = tms ? JTAP_EX1_DR : JTAP_SHF_DR;
         JTAP_SHF_DR: jtap_next = tms ? JTAP_EX1_DR : JTAP_SHF_DR;
         JTAP_EX1_DR: jtap_next = tms ? JTAP_UPD_DR : JTAP_PAU_DR;
         JTAP_PAU_DR: jtap_next = tms ? JTAP_EX2_DR : JTAP_PAU_DR;
         JTAP_EX2_DR: jtap_next = tms ? JTAP_UPD_DR : JTAP_SHF_DR;
         JTAP_UPD_DR: jtap_next = tms ? JTAP_SEL_DR : JTAP_RTI;
         JTAP_SEL_IR: jtap_next = tms ? JTAP_TLR    : JTAP_CAP_IR;
         JTAP_CAP_IR: jtap_next = tms ? JTAP_EX1_IR : JTAP_SHF_IR;
         JTAP_SHF_IR: jtap_next = tms ? JTAP_EX1_IR : JTAP_SHF_IR;
         JTAP_EX1_IR: jtap_next = tms ? JTAP_UPD_IR : JTAP_PAU_IR;
         JTAP_PAU_IR: jtap_next = tms ? JTAP_EX2_IR : JTAP_PAU_IR;
         JTAP_EX2_IR: jtap_next = tms ? JTAP_UPD_IR : JTAP_SHF_IR;
         JTAP_UPD_IR: jtap_next = tms ? JTAP_SEL_DR : JTAP_RTI;
         default:     jtap_next = JTAP_TLR;
      endcase
   endfunction

   always_comb begin
      q_d = q_q;
      if (!i_trst_n) begin
         q_d.st = JTAP_TLR;
      end else if (i_tck_rise) begin
         q_d.st = jtap_next(q_q.st, i_tms); // [R6] [R1] [R10]
      end
   end

   // state resets to JTAP_TLR on i_rst_n at power-up as well as on the tap's own test reset i_trst_n
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         q_q.st <= JTAP_TLR;
      end else begin
         q_q <= q_d; // [R2]
      end
   end

   assign o_state = q_q.st;

   exit_upd_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n || !i_trst_n) // [R10]
      (i_tck_rise && i_tms && (q_q.st == JTAP_EX1_DR || q_q.st == JTAP_EX2_DR))
      |=> (q_q.st == JTAP_UPD_DR))
      else $error("exit-dr with tms high did not reach update-dr");

   hold_no_edge_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // [R6]
      (!i_tck_rise && i_trst_n) |=> $stable(q_q.st))
      else $error("tap state changed without a test clock rise");
endmodule

// >>> verilog/jtap_tap.sv
`timescale 1ns/1ps
`include "jtap_defines.svh"

// Summary of operation
// R1: five tms-high clock rises reach reset state
// R2: no self reset at power-up; here i_rst_n puts the fsm in JTAP_TLR
// R3: tester resets tap after power-up
// R4: tap reset precedes fifo activity
// R5: test control overrides fifo operation
// R6: state changes on tck rise, tms chooses
// R7: capture-dr loads selected register in parallel
// R8: shift-dr lsb first, tdi rise, tdo fall
// R9: update-dr latches shifted data to outputs
// R10: exit-dr with tms high goes update-dr
// R11: pause-dr holds all selected registers
// R12: ir states mirror dr states on ir
// R13: ir takes tdi on each shift rise
// R14: new instruction active only at update-ir
// R15: four-bit ir, lsb nearest tdo
// R16: decode extest sample idcode highz bypass
// R17: bypass loads zero at capture-dr
// R18: fixed 32-bit id with lsb one
// R19: highz instruction floats all outputs
// R20: tdo driven only in shift states
module jtap_tap
   import jtap_pkg::*;
#(
   parameter int                 BSR_W   = 8,
   parameter logic [3:0]         ID_VER  = 4'h0,
   parameter logic [15:0]        ID_PART = 16'h0001, // arbitrary value
   parameter logic [10:0]        ID_MFG  = 11'h001   // arbitrary value
)(
   input  wire logic             i_ref_clk,
   input  wire logic             i_rst_n,
   input  wire logic             i_tck,
   input  wire logic             i_tms,
   input  wire logic             i_tdi,
   input  wire logic             i_trst_n,
   input  wire logic [BSR_W-1:0] i_pins,
   output logic                  o_tdo,
   output logic                  o_tdo_oe,
   output logic [BSR_W-1:0]      o_bsr_out,
   output logic                  o_test_mode,
   output logic                  o_pins_hiz,
   output logic                  o_tap_reset_done
);
   // elaboration stops here for a chain length the shift logic cannot serve
   if (BSR_W < 1 || BSR_W > 256) begin : g_bad_bsr_w
      $error("jtap_tap: bad BSR_W");
   end

   // ****************************************************
   // state
   // ****************************************************
   typedef struct packed {
      jtap_pins_t       s1;
      jtap_pins_t       s2;
      logic             tck_last;
      logic [3:0]       ir_sh;
      logic [3:0]       ir;
      logic             byp;
      logic [31:0]      id_sh;
      logic [BSR_W-1:0] bsr_sh;
      logic [BSR_W-1:0] bsr_out;
      logic             tdo;
      logic             tdo_oe;
      logic             test_mode;
      logic             hiz;
      logic             rst_done;
      logic [BSR_W-1:0] p1;
      logic [BSR_W-1:0] p2;
      logic [2:0]       tms_ones;
   } jtap_tap_q_t;

   jtap_tap_q_t q_q;
   jtap_tap_q_t q_d;
   jtap_state_t st;

   localparam logic [31:0] ID_VAL = {ID_VER, ID_PART, ID_MFG, 1'b1}; // [R18]

   wire tck_rise = q_q.s2.tck & ~q_q.tck_last;
   wire tck_fall = ~q_q.s2.tck & q_q.tck_last;

   jtap_fsm u_fsm (
      .i_ref_clk  (i_ref_clk),
      .i_rst_n    (i_rst_n),
      .i_tck_rise (tck_rise),
      .i_tms      (q_q.s2.tms),
      .i_trst_n   (q_q.s2.trst_n),
      .o_state    (st)
   );

   function automatic logic is_bsr(input logic [3:0] ir);
      is_bsr = (ir == `JTAP_IR_EXTEST) || (ir == `JTAP_IR_SAMPLE); // [R16]
   endfunction

   // ****************************************************
   // datapath
   // ****************************************************
   always_comb begin
      q_d = q_q;
      q_d.s1 = '{tck: i_tck, tms: i_tms, tdi: i_tdi, trst_n: i_trst_n};
      q_d.s2 = q_q.s1;
      q_d.tck_last = q_q.s2.tck;
      // parallel pins come from another domain, so they get two stages as well
      q_d.p1 = i_pins;
      q_d.p2 = q_q.p1;
      // run of tms-high rises, saturating; only the reset check reads it
      if (tck_rise) begin
         if (!q_q.s2.tms) begin
            q_d.tms_ones = 3'h0;
         end else if (q_q.tms_ones != 3'(`JTAP_RESET_ONES - 1)) begin
            q_d.tms_ones = q_q.tms_ones + 3'h1;
         end
      end
      if (st == JTAP_TLR) begin
         q_d.ir = `JTAP_IR_IDCODE;
         q_d.rst_done = 1'b1;
      end
      if (tck_rise) begin
         case (st)
            JTAP_CAP_DR: begin // [R7]
               if (is_bsr(q_q.ir)) q_d.bsr_sh = q_q.p2;
               else if (q_q.ir == `JTAP_IR_IDCODE) q_d.id_sh = ID_VAL;
               else q_d.byp = 1'b0; // [R17]
            end
            JTAP_SHF_DR: begin // [R8]
               if (is_bsr(q_q.ir)) begin
                  q_d.bsr_sh = BSR_W'({q_q.s2.tdi, q_q.bsr_sh} >> 1);
               end else if (q_q.ir == `JTAP_IR_IDCODE) begin
                  q_d.id_sh = {q_q.s2.tdi, q_q.id_sh[31:1]};
               end else begin
                  q_d.byp = q_q.s2.tdi;
               end
            end
            JTAP_UPD_DR: if (is_bsr(q_q.ir)) q_d.bsr_out = q_q.bsr_sh; // [R9]
            JTAP_CAP_IR: q_d.ir_sh = `JTAP_IR_CAPTURE; // [R12]
            JTAP_SHF_IR: q_d.ir_sh = {q_q.s2.tdi, q_q.ir_sh[3:1]}; // [R13] [R15]
            JTAP_UPD_IR: q_d.ir = q_q.ir_sh; // [R14]
            default: ; // pause and exit states hold every register [R11]
         endcase
      end
      if (tck_fall) begin
         q_d.tdo_oe = (st == JTAP_SHF_DR) || (st == JTAP_SHF_IR); // [R20]
         if (st == JTAP_SHF_IR) q_d.tdo = q_q.ir_sh[0];
         else if (is_bsr(q_q.ir)) q_d.tdo = q_q.bsr_sh[0];
         else if (q_q.ir == `JTAP_IR_IDCODE) q_d.tdo = q_q.id_sh[0];
         else q_d.tdo = q_q.byp;
      end
      // extest drives pins from the scan latch, which overrides fifo logic
      q_d.test_mode = (q_q.ir == `JTAP_IR_EXTEST); // [R5]
      q_d.hiz = (q_q.ir == `JTAP_IR_HIGHZ); // [R19]
      if (!q_q.s2.trst_n) begin
         q_d.ir = `JTAP_IR_IDCODE;
         q_d.rst_done = 1'b1;
      end
   end

   // power-up reset loads idcode into the ir and clears the done flag; tap reset loads idcode and sets the flag
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         q_q <= '0;
         q_q.s1.trst_n <= 1'b1;
         q_q.s2.trst_n <= 1'b1;
         q_q.ir <= `JTAP_IR_IDCODE;
      end else begin
         q_q <= q_d;
      end
   end

   assign o_tdo            = q_q.tdo;
   assign o_tdo_oe         = q_q.tdo_oe;
   assign o_bsr_out        = q_q.bsr_out;
   assign o_test_mode      = q_q.test_mode;
   assign o_pins_hiz       = q_q.hiz;
   assign o_tap_reset_done = q_q.rst_done;

   // ****************************************************
   // checks
   // ****************************************************
   tdo_shift_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // [R20]
      (tck_fall && st != JTAP_SHF_DR && st != JTAP_SHF_IR) |=> !o_tdo_oe)
      else $error("tdo enabled outside shift");

   byp_zero_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // [R17]
      (tck_rise && st == JTAP_CAP_DR && q_q.ir == `JTAP_IR_BYPASS) |=> !q_q.byp)
      else $error("bypass not zeroed at capture");

   id_load_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // [R18]
      (tck_rise && st == JTAP_CAP_DR && q_q.ir == `JTAP_IR_IDCODE) |=> q_q.id_sh == ID_VAL)
      else $error("id value not captured");

   ir_hold_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // [R14]
      (st != JTAP_UPD_IR && st != JTAP_TLR && q_q.s2.trst_n) |=> $stable(q_q.ir))
      else $error("instruction changed outside update-ir");

   pause_hold_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // [R11]
      (st == JTAP_PAU_DR) |=> $stable(q_q.bsr_sh) && $stable(q_q.id_sh))
      else $error("data register moved in pause-dr");

   hiz_dec_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // [R19]
      (q_q.ir == `JTAP_IR_HIGHZ) |=> o_pins_hiz)
      else $error("highz instruction did not float pins");

   upd_latch_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // [R9]
      (tck_rise && st == JTAP_UPD_DR && is_bsr(q_q.ir)) |=> o_bsr_out == $past(q_q.bsr_sh))
      else $error("update-dr did not latch scan data");

   ir_shift_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // [R13]
      (tck_rise && st == JTAP_SHF_IR) |=> q_q.ir_sh[3] == $past(q_q.s2.tdi))
      else $error("ir did not take tdi");

   tms_reset_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // [R1]
      (tck_rise && q_q.s2.tms && q_q.tms_ones == 3'(`JTAP_RESET_ONES - 1))
      |=> (st == JTAP_TLR))
      else $error("five tms-high rises did not reach reset state");

   tlr_ir_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // [R16]
      ((st == JTAP_TLR) || !q_q.s2.trst_n)
      |=> (q_q.ir == `JTAP_IR_IDCODE) && o_tap_reset_done)
      else $error("tap reset did not select the id register");

   ir_upd_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // [R14]
      (tck_rise && st == JTAP_UPD_IR && q_q.s2.trst_n)
      |=> (q_q.ir == $past(q_q.ir_sh)))
      else $error("update-ir did not load the instruction");

   ir_cap_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // [R12]
      (tck_rise && st == JTAP_CAP_IR)
      |=> (q_q.ir_sh == `JTAP_IR_CAPTURE))
      else $error("capture-ir did not load the fixed pattern");

   ir_pause_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // [R12]
      (st == JTAP_PAU_IR || st == JTAP_EX1_IR || st == JTAP_EX2_IR)
      |=> $stable(q_q.ir_sh))
      else $error("ir shift stage moved in pause or exit");

   cap_pins_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // [R7]
      (tck_rise && st == JTAP_CAP_DR && is_bsr(q_q.ir))
      |=> (q_q.bsr_sh == $past(q_q.p2)))
      else $error("capture-dr did not load the pins");

   bsr_shift_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // [R8]
      (tck_rise && st == JTAP_SHF_DR && is_bsr(q_q.ir))
      |=> (q_q.bsr_sh[BSR_W-1] == $past(q_q.s2.tdi)))
      else $error("scan chain did not take tdi");

   id_shift_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // [R8]
      (tck_rise && st == JTAP_SHF_DR && q_q.ir == `JTAP_IR_IDCODE)
      |=> (q_q.id_sh[31] == $past(q_q.s2.tdi)))
      else $error("id register did not take tdi");

   byp_shift_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // [R8]
      (tck_rise && st == JTAP_SHF_DR && !is_bsr(q_q.ir) && q_q.ir != `JTAP_IR_IDCODE)
      |=> (q_q.byp == $past(q_q.s2.tdi)))
      else $error("bypass stage did not take tdi");

   exit_hold_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // [R10]
      (st == JTAP_EX1_DR || st == JTAP_EX2_DR)
      |=> $stable(q_q.bsr_sh) && $stable(q_q.id_sh) && $stable(q_q.byp))
      else $error("data register moved in exit-dr");

   pause_byp_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // [R11]
      (st == JTAP_PAU_DR)
      |=> $stable(q_q.byp))
      else $error("bypass stage moved in pause-dr");

   // ****************************************************
   // output checks
   // ****************************************************
   tdo_on_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // [R20]
      (tck_fall && (st == JTAP_SHF_DR || st == JTAP_SHF_IR))
      |=> o_tdo_oe)
      else $error("tdo not enabled in shift");

   tdo_ir_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // [R15]
      (tck_fall && st == JTAP_SHF_IR)
      |=> (o_tdo == $past(q_q.ir_sh[0])))
      else $error("tdo did not show the ir lsb");

   tdo_dr_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // [R8]
      (tck_fall && st == JTAP_SHF_DR && is_bsr(q_q.ir))
      |=> (o_tdo == $past(q_q.bsr_sh[0])))
      else $error("tdo did not show the chain lsb");

   tdo_still_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // [R8]
      (!tck_fall)
      |=> $stable(o_tdo) && $stable(o_tdo_oe))
      else $error("tdo changed away from a falling test clock");

   out_hold_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // [R9]
      !(tck_rise && st == JTAP_UPD_DR)
      |=> $stable(o_bsr_out))
      else $error("scan latch changed outside update-dr");

   mode_on_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // [R5]
      (q_q.ir == `JTAP_IR_EXTEST)
      |=> o_test_mode)
      else $error("extest did not take over the pins");

   mode_off_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // [R5]
      (q_q.ir != `JTAP_IR_EXTEST)
      |=> !o_test_mode)
      else $error("test mode without extest");

   hiz_off_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n) // [R19]
      (q_q.ir != `JTAP_IR_HIGHZ)
      |=> !o_pins_hiz)
      else $error("pins floated without the highz instruction");
endmodule

// >>> verification/jtap_tester.sv
`timescale 1ns/1ps

// ************************************************************
// external test controller: tck runs only while it scans or resets the tap
// ************************************************************
module jtap_tester (
   output logic      o_tck,
   output logic      o_tms,
   output logic      o_tdi,
   output logic      o_trst_n,
   input  wire logic i_tdo,
   input  wire logic i_tdo_oe
);
   logic so;

   initial begin
      o_tck    = 1'b0;
      o_tms    = 1'b1;
      o_tdi    = 1'b0;
      o_trst_n = 1'b1;
   end

   // tdo is taken late in the high phase: the synchroniser delays it by several ref cycles
   task automatic tick(input logic tms, input logic tdi);
      o_tms = tms;
      o_tdi = tdi;
      #40 o_tck = 1'b1;
      #39 so = i_tdo_oe ? i_tdo : 1'bx;
      #1 o_tck = 1'b0;
   endtask

   task automatic tlr_by_tms();
      repeat (5) tick(1'b1, 1'b0);
      tick(1'b0, 1'b0);
   endtask

   task automatic tlr_by_trst();
      o_trst_n = 1'b0;
      #100 o_trst_n = 1'b1;
      #100 tick(1'b0, 1'b0);
   endtask

   // from idle; a pause of two cycles follows bit pz when pz < n - 1
   task automatic scan(input logic ir, input int n, input int pz, input logic [31:0] din,
                       output logic [31:0] dout);
      dout = '0;
      tick(1'b1, 1'b0);
      if (ir)
         tick(1'b1, 1'b0);
      tick(1'b0, 1'b0);
      tick(1'b0, 1'b0);
      for (int i = 0; i < n; i++) begin
         tick((i == n - 1) || (i == pz), din[i]);
         dout[i] = so;
         if (i == pz && i != n - 1) begin
            tick(1'b0, 1'b0);
            tick(1'b0, 1'b0);
            tick(1'b1, 1'b0);
            tick(1'b0, 1'b0);
         end
      end
      tick(1'b1, 1'b0);
      tick(1'b0, 1'b0);
   endtask
endmodule

// >>> verification/testbench.sv
`timescale 1ns/1ps

// ************************************************************
// testbench
// ************************************************************
module testbench;
   import jtap_pkg::*;

   localparam logic [31:0] IDV = {4'h5, 16'h1234, 11'h0AB, 1'b1}; // arbitrary value

   logic        i_ref_clk;
   logic        i_rst_n;
   logic        tck, tms, tdi, trst_n;
   logic [7:0]  pins;
   logic [7:0]  bsr_out;
   logic        tdo, tdo_oe, test_mode, pins_hiz, reset_done;
   logic [31:0] r;
   int          n_errors, cmp_count;

   jtap_tap #(.BSR_W(8), .ID_VER(IDV[31:28]), .ID_PART(IDV[27:12]), .ID_MFG(IDV[11:1])) DUT (
      .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_tck(tck), .i_tms(tms), .i_tdi(tdi),
      .i_trst_n(trst_n), .i_pins(pins), .o_tdo(tdo), .o_tdo_oe(tdo_oe), .o_bsr_out(bsr_out),
      .o_test_mode(test_mode), .o_pins_hiz(pins_hiz), .o_tap_reset_done(reset_done));

   jtap_tester ctl (.o_tck(tck), .o_tms(tms), .o_tdi(tdi), .o_trst_n(trst_n), .i_tdo(tdo),
                    .i_tdo_oe(tdo_oe));

   initial i_ref_clk = 1'b0;
   always #5 i_ref_clk = ~i_ref_clk;

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask

   task automatic test_done();
      $display("compares %0d, mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic t_idcode();
      ctl.tlr_by_tms();
      check("reset_done", 1, reset_done);
      check("tdo_oe idle", 0, tdo_oe);
      ctl.scan(1'b0, 32, 99, 32'h0, r);
      check("idcode", IDV, r);
      $display("idcode test ended");
   endtask

   task automatic t_bypass();
      ctl.scan(1'b1, 4, 99, 32'hF, r);
      check("ir capture", 32'h1, r);
      ctl.scan(1'b0, 8, 99, 32'hA5, r);
      check("bypass out", 32'h4A, r);
      $display("bypass test ended");
   endtask

   // parallel pins must arrive unchanged although the shift pauses mid-scan
   task automatic t_sample();
      @(posedge i_ref_clk);
      #1 pins = 8'h3C;
      ctl.scan(1'b1, 4, 2, 32'h1, r);
      check("ir capture paused", 32'h1, r);
      ctl.scan(1'b0, 8, 3, 32'h96, r);
      check("captured pins", 32'h3C, r);
      check("update latch", 32'h96, {24'h0, bsr_out});
      check("test mode off", 0, test_mode);
      $display("sample test ended");
   endtask

   task automatic t_modes();
      ctl.scan(1'b1, 4, 99, 32'h0, r);
      check("extest mode", 1, test_mode);
      check("hiz off", 0, pins_hiz);
      ctl.scan(1'b1, 4, 99, 32'h3, r);
      check("hiz on", 1, pins_hiz);
      check("extest left", 0, test_mode);
      ctl.tlr_by_tms();
      check("hiz after tms reset", 0, pins_hiz);
      $display("mode test ended");
   endtask

   task automatic t_trst();
      ctl.scan(1'b1, 4, 99, 32'h3, r);
      check("ir capture before trst", 32'h1, r);
      check("hiz before trst", 1, pins_hiz);
      ctl.tlr_by_trst();
      check("hiz after trst", 0, pins_hiz);
      ctl.scan(1'b0, 32, 99, 32'h0, r);
      check("idcode after trst", IDV, r);
      $display("trst test ended");
   endtask

   initial begin
      n_errors  = 0;
      cmp_count = 0;
      i_rst_n   = 1'b0;
      pins      = 8'h00;
      repeat (5) @(posedge i_ref_clk);
      #1;
      check("reset_done in reset", 0, reset_done);
      i_rst_n = 1'b1;
      repeat (3) @(posedge i_ref_clk);
      #1;
      t_idcode();
      t_bypass();
      t_sample();
      t_modes();
      t_trst();
      test_done();
   end

   // the run needs about 14 us; some fourteen times that means a hang
   initial begin
      #200000;
      n_errors++;
      test_done();
   end
endmodule
